// File: cssc_pkg.sv
// Constants for the clock source and start-up control block
package cssc_pkg;
    localparam logic [3:0] SRCSEL_EXT = 4'h0;
    localparam logic [3:0] SRCSEL_RC8M = 4'h2;
    localparam logic [3:0] SRCSEL_RC128K = 4'h4;
    localparam logic [3:0] SRCSEL_LFXTAL = 4'h6;
    localparam logic [3:0] SRCSEL_DEFAULT = 4'h2;
    localparam logic [1:0] STARTUP_DEFAULT = 2'h2;
    localparam logic [1:0] STARTUP_SHORT = 2'h0;
    localparam logic [1:0] STARTUP_4MS = 2'h1;
    localparam logic [1:0] STARTUP_64MS = 2'h2;
    localparam logic [1:0] STARTUP_RESERVED = 2'h3;
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam int WD_CYCLES_4MS = 512;
    localparam int WD_CYCLES_64MS = 8192;
    localparam logic [13:0] WD_COUNT_4MS = 14'(WD_CYCLES_4MS);
    localparam logic [13:0] WD_COUNT_64MS = 14'(WD_CYCLES_64MS);
    localparam logic [4:0] RESET_SRC_CYCLES = 5'h0e;
    localparam logic [4:0] WAKE_SRC_CYCLES = 5'h06;
    localparam logic [3:0] PRESCALE_DIV8 = 4'h3;
    localparam logic [3:0] PRESCALE_DIV1 = 4'h0;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    typedef enum logic [2:0] {
        CSSC_IDLE_RESET = 3'b000,
        CSSC_WD_DELAY = 3'b001,
        CSSC_SRC_COUNT = 3'b010,
        CSSC_RUN = 3'b011,
        CSSC_SLEEP = 3'b100
    } cssc_state_t;
    typedef enum logic [2:0] {
        CSSC_SRC_EXT = 3'b000,
        CSSC_SRC_RC8M = 3'b001,
        CSSC_SRC_RC128K = 3'b010,
        CSSC_SRC_LFXTAL = 3'b011,
        CSSC_SRC_XTAL = 3'b100,
        CSSC_SRC_RSVD = 3'b101
    } cssc_source_t;
endpackage : cssc_pkg

// File: cssc_clock_control.sv
// Clock source decode, start-up timing and clock domain gating
`timescale 1ns/10ps
// What this block does
// (RULE_01) Decode four-bit source select: external, RC 8 MHz, 128 kHz, LF crystal, crystal.
// (RULE_02) Fuse bit one means unprogrammed, zero means programmed.
// (RULE_03) On wake from power-down count source cycles before execution resumes.
// (RULE_04) After reset add a delay timed on watchdog oscillator cycles.
// (RULE_05) 4 ms is 512 watchdog cycles, 64 ms is 8192 watchdog cycles.
// (RULE_06) Simple sources wake in 6 cycles; reset delay 14, +4 ms, +64 ms.
// (RULE_07) Reset pin disabled extends the short reset delay of RC sources by 4 ms.
// (RULE_08) Default fuses: RC 8 MHz source and longest start-up code.
// (RULE_09) Reset loads the factory calibration into the oscillator trim register.
// (RULE_10) Software may rewrite the trim register and it steers the RC oscillator.
// (RULE_11) Watchdog and reset time-out always run from the watchdog oscillator.
// (RULE_12) External clock must change under 2% per cycle, larger only in reset.
// (RULE_13) Core clock feeds registers, status and stack; gating it stops the core.
// (RULE_14) Peripheral clock feeds timers; some external interrupts seen while halted.
// (RULE_15) Program memory clock is enabled together with the core clock.
// (RULE_16) Converter clock keeps running while core and peripheral clocks are off; code runs it only in RUN and SLEEP, not in the wake-up count.
// (RULE_17) Divide-by-eight fuse programmed starts the system clock prescaled by 8.
// (RULE_18) Reset: watchdog delay first, then source cycles, then release clocks.
module cssc_clock_control (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic watchdog_osc_tick,
    input wire logic source_clock_tick,
    input wire logic [3:0] clock_source_select_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic reset_pin_disable_fuse,
    input wire logic divide_by_eight_fuse,
    input wire logic [7:0] factory_trim,
    input wire logic trim_write,
    input wire logic [7:0] trim_write_data,
    input wire logic sleep_request,
    input wire logic wake_event,
    input wire logic ext_irq_async,
    output logic [7:0] oscillator_trim_register,
    output logic [2:0] selected_source,
    output logic source_reserved,
    output logic [3:0] prescale_select,
    output logic core_clock_enable,
    output logic peripheral_clock_enable,
    output logic program_memory_clock_enable,
    output logic converter_clock_enable,
    output logic watchdog_clock_enable,
    output logic ext_irq_wake,
    output logic startup_busy
);
    cssc_pkg::cssc_state_t state;
    cssc_pkg::cssc_state_t next_state;
    logic [13:0] wd_count;
    logic [13:0] wd_target;
    logic [4:0] src_count;
    logic [4:0] src_target;
    logic waking;
    cssc_pkg::cssc_source_t src_kind;

    function automatic cssc_pkg::cssc_source_t decode_source(input logic [3:0] sel);
        if (sel[3]) begin
            decode_source = cssc_pkg::CSSC_SRC_XTAL; // RULE_01
        end else begin
            unique case (sel)
                cssc_pkg::SRCSEL_EXT: decode_source = cssc_pkg::CSSC_SRC_EXT;
                cssc_pkg::SRCSEL_RC8M: decode_source = cssc_pkg::CSSC_SRC_RC8M;
                cssc_pkg::SRCSEL_RC128K: decode_source = cssc_pkg::CSSC_SRC_RC128K;
                cssc_pkg::SRCSEL_LFXTAL: decode_source = cssc_pkg::CSSC_SRC_LFXTAL;
                default: decode_source = cssc_pkg::CSSC_SRC_RSVD;
            endcase
        end
    endfunction : decode_source

    // Core, peripheral and program memory clocks run only in RUN
    function automatic logic clocks_released(input cssc_pkg::cssc_state_t s);
        clocks_released = (s == cssc_pkg::CSSC_RUN);
    endfunction : clocks_released

    // Start-up finished: running, or asleep after a completed boot
    function automatic logic startup_done(input cssc_pkg::cssc_state_t s);
        startup_done = (s == cssc_pkg::CSSC_RUN || s == cssc_pkg::CSSC_SLEEP);
    endfunction : startup_done

    // Live fuse decode; fuses are static between resets
    assign src_kind = decode_source(clock_source_select_fuses);

    // Real-time part of the reset delay in watchdog cycles
    always_comb begin
        unique case (startup_time_fuses)
            cssc_pkg::STARTUP_SHORT: begin
                if (reset_pin_disable_fuse == cssc_pkg::FUSE_PROGRAMMED && // RULE_02
                    (src_kind == cssc_pkg::CSSC_SRC_RC8M ||
                     src_kind == cssc_pkg::CSSC_SRC_RC128K)) begin
                    wd_target = cssc_pkg::WD_COUNT_4MS; // RULE_07
                end else begin
                    wd_target = 14'h0000; // RULE_06
                end
            end
            cssc_pkg::STARTUP_4MS: wd_target = cssc_pkg::WD_COUNT_4MS; // RULE_05
            cssc_pkg::STARTUP_64MS: wd_target = cssc_pkg::WD_COUNT_64MS; // RULE_05
            // Reserved start-up code falls back to the longest delay
            cssc_pkg::STARTUP_RESERVED: wd_target = cssc_pkg::WD_COUNT_64MS;
        endcase
    end

    assign src_target = waking ? cssc_pkg::WAKE_SRC_CYCLES : cssc_pkg::RESET_SRC_CYCLES; // RULE_06

    always_comb begin
        next_state = state;
        unique case (state)
            cssc_pkg::CSSC_IDLE_RESET: next_state = cssc_pkg::CSSC_WD_DELAY;
            cssc_pkg::CSSC_WD_DELAY: begin
                if (wd_count >= wd_target) begin
                    next_state = cssc_pkg::CSSC_SRC_COUNT; // RULE_18
                end
            end
            cssc_pkg::CSSC_SRC_COUNT: begin
                if (src_count >= src_target) begin
                    next_state = cssc_pkg::CSSC_RUN; // RULE_03
                end
            end
            cssc_pkg::CSSC_RUN: begin
                if (sleep_request) begin
                    next_state = cssc_pkg::CSSC_SLEEP;
                end
            end
            cssc_pkg::CSSC_SLEEP: begin
                if (wake_event || ext_irq_async) begin
                    next_state = cssc_pkg::CSSC_SRC_COUNT; // RULE_03
                end
            end
            default: next_state = cssc_pkg::CSSC_IDLE_RESET;
        endcase
    end

    // Reset returns to the idle cycle ahead of both delays
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= cssc_pkg::CSSC_IDLE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Marks a wake from power-down, which takes the shorter count
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            waking <= 1'b0;
        end else if (state == cssc_pkg::CSSC_SLEEP && next_state == cssc_pkg::CSSC_SRC_COUNT) begin
            waking <= 1'b1;
        end else if (state == cssc_pkg::CSSC_RUN) begin
            waking <= 1'b0;
        end
    end

    // Watchdog-timed delay, never from the system source
    always_ff @(posedge sys_clk) begin
        if (reset || state != cssc_pkg::CSSC_WD_DELAY) begin
            wd_count <= 14'h0000;
        end else if (watchdog_osc_tick && wd_count < wd_target) begin
            wd_count <= wd_count + 14'h0001; // RULE_04 RULE_11
        end
    end

    // Source-clock cycles: 14 after reset, 6 after a wake
    always_ff @(posedge sys_clk) begin
        if (reset || state != cssc_pkg::CSSC_SRC_COUNT) begin
            src_count <= 5'h00;
        end else if (source_clock_tick && src_count < src_target) begin
            src_count <= src_count + 5'h01; // RULE_03
        end
    end

    // A trim write in the load cycle loses to the factory value
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            oscillator_trim_register <= cssc_pkg::TRIM_RESET;
        end else if (state == cssc_pkg::CSSC_IDLE_RESET) begin
            oscillator_trim_register <= factory_trim; // RULE_09
        end else if (trim_write) begin
            oscillator_trim_register <= trim_write_data; // RULE_10
        end
    end

    // Start-up prescale from the divide fuse, loaded once per reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prescale_select <= cssc_pkg::PRESCALE_DIV8;
        end else if (state == cssc_pkg::CSSC_IDLE_RESET) begin
            prescale_select <= (divide_by_eight_fuse == cssc_pkg::FUSE_PROGRAMMED) ?
                cssc_pkg::PRESCALE_DIV8 : cssc_pkg::PRESCALE_DIV1; // RULE_17
        end
    end

    // Enables taken from next_state so they line up with the state
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            core_clock_enable <= 1'b0;
            peripheral_clock_enable <= 1'b0;
            program_memory_clock_enable <= 1'b0;
            converter_clock_enable <= 1'b0;
            startup_busy <= 1'b1;
        end else begin
            core_clock_enable <= clocks_released(next_state); // RULE_13 RULE_18
            peripheral_clock_enable <= clocks_released(next_state); // RULE_14
            program_memory_clock_enable <= clocks_released(next_state); // RULE_15
            converter_clock_enable <= startup_done(next_state); // RULE_16
            startup_busy <= !startup_done(next_state);
        end
    end

    // Reserved source or start-up codes are flagged but still boot
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            watchdog_clock_enable <= 1'b0;
            ext_irq_wake <= 1'b0;
            selected_source <= decode_source(cssc_pkg::SRCSEL_DEFAULT); // RULE_08
            source_reserved <= 1'b0;
        end else begin
            watchdog_clock_enable <= 1'b1; // RULE_11
            ext_irq_wake <= ext_irq_async && state == cssc_pkg::CSSC_SLEEP; // RULE_14
            selected_source <= src_kind; // RULE_01
            source_reserved <= src_kind == cssc_pkg::CSSC_SRC_RSVD ||
                startup_time_fuses == cssc_pkg::STARTUP_RESERVED;
        end
    end
endmodule : cssc_clock_control

// File: cssc_asserts.sv
// Assertion checker for the clock control block
`timescale 1ns/10ps
module cssc_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] clock_source_select_fuses,
    input wire logic divide_by_eight_fuse,
    input wire logic [7:0] factory_trim,
    input wire logic trim_write,
    input wire logic [7:0] trim_write_data,
    input wire logic [7:0] oscillator_trim_register,
    input wire logic [2:0] selected_source,
    input wire logic [3:0] prescale_select,
    input wire logic core_clock_enable,
    input wire logic peripheral_clock_enable,
    input wire logic program_memory_clock_enable,
    input wire logic converter_clock_enable,
    input wire logic watchdog_clock_enable,
    input wire logic ext_irq_async,
    input wire logic ext_irq_wake,
    input wire logic startup_busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic [2:0] exp_src;
    always_comb begin
        if (clock_source_select_fuses[3]) begin
            exp_src = 3'h4;
        end else if (clock_source_select_fuses[0]) begin
            exp_src = 3'h5;
        end else begin
            exp_src = {1'b0, clock_source_select_fuses[2:1]};
        end
    end
    sequence s_trim_loaded;
        ##[1:3] oscillator_trim_register == factory_trim;
    endsequence
    a_mem_with_core: assert property (program_memory_clock_enable == core_clock_enable)
        else $error("memory clock differs from core clock");
    a_periph_with_core: assert property (peripheral_clock_enable == core_clock_enable)
        else $error("peripheral clock differs from core clock");
    a_conv_outlives_core: assert property ($fell(core_clock_enable) |-> converter_clock_enable)
        else $error("converter clock off while core gated");
    a_busy_blocks_core: assert property (startup_busy |-> !core_clock_enable)
        else $error("core clock on during start-up");
    a_release_on_done: assert property ($fell(startup_busy) |-> core_clock_enable)
        else $error("clocks not released at end of start-up");
    a_source_decode: assert property (core_clock_enable |-> selected_source == exp_src)
        else $error("source select decoded wrongly");
    a_prescale_fuse: assert property (core_clock_enable |->
        prescale_select == (divide_by_eight_fuse ? 4'h0 : 4'h3))
        else $error("prescale does not follow fuse");
    a_trim_write: assert property (trim_write && core_clock_enable |=>
        oscillator_trim_register == $past(trim_write_data))
        else $error("trim write not applied");
    a_trim_reset_load: assert property ($fell(reset) |-> s_trim_loaded)
        else $error("factory trim not loaded");
    a_reset_quiet: assert property ($fell(reset) |-> startup_busy && !converter_clock_enable)
        else $error("outputs not quiet during reset");
    a_wd_clock_on: assert property (!$past(reset) |-> watchdog_clock_enable)
        else $error("watchdog clock not running");
    a_irq_wake: assert property (ext_irq_async && !startup_busy && !core_clock_enable |=>
        ext_irq_wake)
        else $error("asynchronous interrupt did not wake");
endmodule : cssc_asserts
bind cssc_clock_control cssc_asserts i_cssc_asserts (.sys_clk, .reset,
    .clock_source_select_fuses, .divide_by_eight_fuse, .factory_trim, .trim_write,
    .trim_write_data, .oscillator_trim_register, .selected_source, .prescale_select,
    .core_clock_enable, .peripheral_clock_enable, .program_memory_clock_enable,
    .converter_clock_enable, .watchdog_clock_enable, .ext_irq_async, .ext_irq_wake,
    .startup_busy);

// File: cssc_ext_source.sv
// External clock source model: one tick every PERIOD system cycles
`timescale 1ns/10ps
module cssc_ext_source #(
    parameter int PERIOD = 3
) (
    input wire logic sys_clk,
    output logic source_clock_tick = 1'b0
);
    int phase = 0;
    // Fixed period, so no cycle-to-cycle frequency step at all
    always @(posedge sys_clk) begin
        phase <= (phase + 1) % PERIOD;
        source_clock_tick <= (phase == PERIOD - 1);
    end
endmodule : cssc_ext_source

// File: testbench.sv
// Self-checking testbench for the clock control block
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 0;
    logic reset = 1;
    logic wd = 0;
    logic src;
    logic [3:0] cs = 4'h2;
    logic [1:0] st = 2'h2;
    logic rd = 1;
    logic div8 = 1;
    logic [7:0] fac = 8'ha5;
    logic twr = 0;
    logic [7:0] tdat = 8'h00;
    logic slp = 0;
    logic wake = 0;
    logic irq = 0;
    logic [7:0] trim;
    logic [3:0] pre;
    logic rsvd, core, conv, busy;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    cssc_ext_source i_cssc_ext_source (.sys_clk(sys_clk), .source_clock_tick(src));
    cssc_clock_control i_cssc_clock_control (.sys_clk(sys_clk), .reset(reset),
        .watchdog_osc_tick(wd), .source_clock_tick(src), .clock_source_select_fuses(cs),
        .startup_time_fuses(st), .reset_pin_disable_fuse(rd), .divide_by_eight_fuse(div8),
        .factory_trim(fac), .trim_write(twr), .trim_write_data(tdat), .sleep_request(slp),
        .wake_event(wake), .ext_irq_async(irq), .oscillator_trim_register(trim),
        .selected_source(), .source_reserved(rsvd), .prescale_select(pre),
        .core_clock_enable(core), .peripheral_clock_enable(), .program_memory_clock_enable(),
        .converter_clock_enable(conv), .watchdog_clock_enable(), .ext_irq_wake(),
        .startup_busy(busy));
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        wd <= ~wd;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Cycles until the core clock is released, bounded
    task automatic until_ready();
        n = 0;
        while (core !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (core !== 1'b1) check(16'(core), 16'h0001);
    endtask : until_ready
    task automatic win(input int lo);
        check(16'((n >= lo && n <= lo + 12) ? lo : n), 16'(lo));
    endtask : win
    task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic r, input int t);
        @(posedge sys_clk);
        reset <= 1;
        cs <= c;
        st <= s;
        rd <= r;
        div8 <= ~div8;
        repeat (6) @(posedge sys_clk);
        reset <= 0;
        until_ready();
        if (t >= 0) win(2 * t + 38);
        check(trim, fac);
        check(pre, div8 ? 4'h0 : 4'h3);
        check(rsvd, (c[3] == 1'b0 && c[0] == 1'b1) || s == 2'h3);
    endtask : boot
    initial begin
        boot(4'h2, 2'h0, 1'b1, 0);
        boot(4'h2, 2'h0, 1'b0, 512);
        boot(4'h4, 2'h0, 1'b0, 512);
        boot(4'h0, 2'h0, 1'b0, 0);
        boot(4'h0, 2'h1, 1'b1, 512);
        boot(4'h4, 2'h1, 1'b1, 512);
        boot(4'h6, 2'h0, 1'b1, -1);
        boot(4'h9, 2'h0, 1'b1, -1);
        boot(4'h1, 2'h0, 1'b1, -1);
        boot(4'h2, 2'h2, 1'b1, 8192);
        boot(4'h0, 2'h3, 1'b1, 8192);
        @(posedge sys_clk);
        twr <= 1;
        tdat <= 8'h5a;
        @(posedge sys_clk);
        twr <= 0;
        #1 check(trim, 8'h5a);
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            slp <= 1;
            @(posedge sys_clk);
            slp <= 0;
            repeat (3) @(posedge sys_clk);
            #1 check(core, 1'b0);
            check(conv, 1'b1);
            @(posedge sys_clk);
            wake <= (i == 0);
            irq <= (i == 1);
            until_ready();
            win(14);
            wake <= 0;
            irq <= 0;
        end
        final_report();
    end
endmodule : testbench
